// file: logic/rts_pkg.sv
// Constants, field layouts, reset values and state codes for the radio test and status registers.
// Assumes a host register port synchronous to the device clock; codes come from the radio controller.
// Function
// - Test and calibration registers lose their contents when the radio enters sleep.
// - Production test value 0xBF enables the temperature sensor while idle.
// - Oscillator-selection calibration stage runs only while test settings A bit 1 is set.
// - Test settings reset to 0x88, 0x31 and fields 0x02/1/1.
// - Read-only status registers start at 0x30, mirrored from 0xF0 upward.
// - Fixed 8-bit part number and revision identifiers are readable.
// - Carrier offset estimate is 8-bit two's complement, step crystal over 2^14.
// - Offset estimate reads zero under amplitude or on-off keying.
// - Link quality bit 7 shows last CRC match; cleared on receive entry or restart.
// - Link quality bits 6:0 estimated over 64 symbols after the sync word.
// - Received signal strength readable as an 8-bit status register.
// - Radio state code in bits 4:0, bits 7:5 read zero.
// - State codes 0 to 22 report sleep, idle, calibration, settling, receive and transmit.
package rts_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses
    localparam logic [7:0] SYNTH_TEST_CONTROL_ADDR = 8'h29;
    localparam logic [7:0] PRODUCTION_TEST_ADDR = 8'h2A;
    localparam logic [7:0] GAIN_CONTROL_TEST_ADDR = 8'h2B;
    localparam logic [7:0] TEST_SETTINGS_C_ADDR = 8'h2C;
    localparam logic [7:0] TEST_SETTINGS_B_ADDR = 8'h2D;
    localparam logic [7:0] TEST_SETTINGS_A_ADDR = 8'h2E;
    localparam logic [7:0] PART_NUMBER_ID_ADDR = 8'h30;
    localparam logic [7:0] CHIP_REVISION_ID_ADDR = 8'h31;
    localparam logic [7:0] FREQ_OFFSET_ESTIMATE_ADDR = 8'h32;
    localparam logic [7:0] LINK_QUALITY_STATUS_ADDR = 8'h33;
    localparam logic [7:0] SIGNAL_STRENGTH_ADDR = 8'h34;
    localparam logic [7:0] RADIO_FSM_STATE_ADDR = 8'h35;
    // Status mirror window
    localparam logic [7:0] STATUS_BASE = 8'h30;
    localparam logic [7:0] ALT_STATUS_BASE = 8'hF0;
    localparam logic [7:0] ALT_STATUS_LAST = 8'hF5;
    localparam logic [7:0] ALT_OFFSET = ALT_STATUS_BASE - STATUS_BASE;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] SYNTH_TEST_CONTROL_RESET = 8'h59;
    localparam logic [7:0] PRODUCTION_TEST_RESET = 8'h7F;
    localparam logic [7:0] GAIN_CONTROL_TEST_RESET = 8'h3F;
    localparam logic [7:0] TEST_SETTINGS_C_RESET = 8'h88;
    localparam logic [7:0] TEST_SETTINGS_B_RESET = 8'h31;
    localparam logic [5:0] TEST_SETTINGS_A_HIGH_RESET = 6'h02;
    localparam logic TEST_SETTINGS_A_CAL_RESET = 1'b1;
    localparam logic TEST_SETTINGS_A_LOW_RESET = 1'b1;
    localparam logic [7:0] TEST_SETTINGS_A_RESET =
        {TEST_SETTINGS_A_HIGH_RESET, TEST_SETTINGS_A_CAL_RESET, TEST_SETTINGS_A_LOW_RESET};

    ////////////////////////////////////////////////////////////////////////////////
    // Fields and special values
    localparam int OSC_SELECT_CAL_ENABLE_BIT = 1;
    localparam int CRC_MATCH_BIT = 7;
    localparam int FSM_CODE_WIDTH = 5;
    localparam int LQI_WIDTH = 7;
    localparam int LQI_SYMBOLS = 64;
    localparam logic [7:0] TEMP_SENSOR_ENABLE_VALUE = 8'hBF;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [2:0] FSM_RESERVED_ZERO = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Radio controller state codes
    typedef enum logic [FSM_CODE_WIDTH-1:0] {
        FSM_SLEEP = 5'h00, FSM_IDLE = 5'h01, FSM_CRYSTAL_OFF = 5'h02,
        FSM_MANUAL_CALIBRATION_STATE_OSC_ON = 5'h03, FSM_MANUAL_CALIBRATION_STATE_REG_ON = 5'h04, FSM_MANUAL_CALIBRATION = 5'h05,
        FSM_WAKE_OSC_ON = 5'h06, FSM_WAKE_REG_ON = 5'h07, FSM_CAL_START = 5'h08,
        FSM_BANDWIDTH_BOOST = 5'h09, FSM_SYNTH_LOCK = 5'h0A, FSM_IF_ADC_ON = 5'h0B,
        FSM_CAL_END = 5'h0C, FSM_RX = 5'h0D, FSM_RX_END = 5'h0E, FSM_RX_RESTART = 5'h0F,
        FSM_TX_TO_RX = 5'h10, FSM_RX_OVERFLOW = 5'h11, FSM_SYNTH_TX_ON = 5'h12,
        FSM_TX = 5'h13, FSM_TX_END = 5'h14, FSM_RX_TO_TX = 5'h15, FSM_TX_UNDERFLOW = 5'h16
    } rts_fsm_code_type;

    // Link quality collector phase, one bit apart
    typedef enum logic {
        LQI_IDLE = 1'b0,
        LQI_COLLECT = 1'b1
    } rts_lqi_phase_type;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0] synth_test_control;
        logic [7:0] production_test;
        logic [7:0] gain_control_test;
        logic [7:0] test_settings_c;
        logic [7:0] test_settings_b;
        logic [7:0] test_settings_a;
        logic [7:0] carrier_offset_value;
        logic crc_match;
        logic [LQI_WIDTH-1:0] link_quality_value;
        logic [7:0] signal_strength;
        logic [7:0] rdata;
        logic rvalid;
    } rts_bank_type;

endpackage

// file: logic/rts_lqi_if.sv
// Signals between the register bank and its link quality collector.
// Assumes both ends share the bank's clock.
interface rts_lqi_if;
    logic sync_found;
    logic symbol_strobe;
    logic [rts_pkg::LQI_WIDTH-1:0] symbol_quality;
    logic [rts_pkg::LQI_WIDTH-1:0] lqi_value;
    logic lqi_done;

    modport calc (
        input sync_found,
        input symbol_strobe,
        input symbol_quality,
        output lqi_value,
        output lqi_done
    );

    modport bank (
        output sync_found,
        output symbol_strobe,
        output symbol_quality,
        input lqi_value,
        input lqi_done
    );
endinterface

// file: logic/rts_lqi_calc.sv
// Link quality collector: averages per-symbol quality over a window after the sync word.
// Assumes one symbol strobe per received symbol; a new sync word restarts the window.
module rts_lqi_calc #(
    parameter int SYMBOLS = rts_pkg::LQI_SYMBOLS
) (
    input wire logic clock,
    input wire logic rst_n,
    rts_lqi_if.calc lq
);
    localparam int CW = $clog2(SYMBOLS);
    localparam int SW = rts_pkg::LQI_WIDTH + CW;
    localparam logic [CW-1:0] LAST = CW'(SYMBOLS - 1);

    // Power of two keeps the average a plain shift
    if (SYMBOLS < 2 || (1 << CW) != SYMBOLS) begin : g_check
        $error("rts_lqi_calc: SYMBOLS must be a power of two of at least 2");
    end

    typedef struct packed {
        rts_pkg::rts_lqi_phase_type phase;
        logic [CW-1:0] count;
        logic [SW-1:0] sum;
        logic [rts_pkg::LQI_WIDTH-1:0] value;
        logic done;
    } rts_lqi_state_type;

    rts_lqi_state_type st_r;
    rts_lqi_state_type st_nxt;
    logic [SW-1:0] sum_add;

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulate the window; sync word wins over a stray symbol strobe
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        sum_add = st_r.sum + SW'(lq.symbol_quality);
        case (st_r.phase)
            rts_pkg::LQI_IDLE: begin
                st_nxt.phase = rts_pkg::LQI_IDLE;
            end
            rts_pkg::LQI_COLLECT: begin
                if (lq.symbol_strobe) begin
                    st_nxt.sum = sum_add;
                    st_nxt.count = st_r.count + 1'b1;
                    if (st_r.count == LAST) begin
                        st_nxt.value = sum_add[SW-1:CW];
                        st_nxt.done = 1'b1;
                        st_nxt.phase = rts_pkg::LQI_IDLE;
                    end
                end
            end
            default: st_nxt.phase = rts_pkg::LQI_IDLE;
        endcase
        if (lq.sync_found) begin
            st_nxt.phase = rts_pkg::LQI_COLLECT;
            st_nxt.count = '0;
            st_nxt.sum = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lq.lqi_value = st_r.value;
    assign lq.lqi_done = st_r.done;

    // Window closes exactly on the last symbol
    AST_LQI_WINDOW_END: assert property (@(posedge clock) disable iff (!rst_n)
        st_r.phase == rts_pkg::LQI_COLLECT && st_r.count == LAST && lq.symbol_strobe && !lq.sync_found
        |=> lq.lqi_done && st_r.phase == rts_pkg::LQI_IDLE)
        else $error("link quality not delivered after last window symbol");
endmodule

// file: logic/rts_bank.sv
// Test, calibration and status register bank of the radio, reached through the host register port.
// Assumes the radio controller, demodulator and packet engine supply codes and events on this clock.
module rts_bank #(
    parameter logic [7:0] PART_ID = 8'hA5,     // Arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h5A, // Arbitrary value
    parameter int LQI_SYMBOLS = rts_pkg::LQI_SYMBOLS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic [rts_pkg::FSM_CODE_WIDTH-1:0] radio_fsm_code,
    input wire logic fsk_modulation,
    input wire logic offset_update,
    input wire logic [7:0] demod_offset,
    input wire logic crc_check_done,
    input wire logic crc_match,
    input wire logic rx_start,
    input wire logic sync_found,
    input wire logic symbol_strobe,
    input wire logic [rts_pkg::LQI_WIDTH-1:0] symbol_quality,
    input wire logic signal_strength_update,
    input wire logic [7:0] signal_strength_value,
    input wire logic osc_cal_stage_request,
    output logic osc_cal_stage_run,
    output logic temp_sensor_enable,
    output logic [7:0] synth_test_value,
    output logic [7:0] production_test_value,
    output logic [7:0] gain_test_value,
    output logic [7:0] test_c_value,
    output logic [7:0] test_b_value,
    output logic [7:0] test_a_value
);
    rts_pkg::rts_bank_type st_r;
    rts_pkg::rts_bank_type st_nxt;
    logic [7:0] map_addr;
    logic [7:0] read_word;
    logic asleep;

    rts_lqi_if lq ();

    ////////////////////////////////////////////////////////////////////////////////
    // Link quality collector
    assign lq.sync_found = sync_found;
    assign lq.symbol_strobe = symbol_strobe;
    assign lq.symbol_quality = symbol_quality;

    rts_lqi_calc #(
        .SYMBOLS(LQI_SYMBOLS)
    ) u_lqi (
        .clock(clock),
        .rst_n(rst_n),
        .lq(lq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Address folding: the status mirror window lands on the plain status addresses
    always_comb begin
        if (reg_addr >= rts_pkg::ALT_STATUS_BASE && reg_addr <= rts_pkg::ALT_STATUS_LAST) begin
            map_addr = reg_addr - rts_pkg::ALT_OFFSET;
        end else begin
            map_addr = reg_addr;
        end
    end

    assign asleep = radio_fsm_code == rts_pkg::FSM_SLEEP;

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses answer zero
    always_comb begin
        if (map_addr == rts_pkg::SYNTH_TEST_CONTROL_ADDR) begin
            read_word = st_r.synth_test_control;
        end else if (map_addr == rts_pkg::PRODUCTION_TEST_ADDR) begin
            read_word = st_r.production_test;
        end else if (map_addr == rts_pkg::GAIN_CONTROL_TEST_ADDR) begin
            read_word = st_r.gain_control_test;
        end else if (map_addr == rts_pkg::TEST_SETTINGS_C_ADDR) begin
            read_word = st_r.test_settings_c;
        end else if (map_addr == rts_pkg::TEST_SETTINGS_B_ADDR) begin
            read_word = st_r.test_settings_b;
        end else if (map_addr == rts_pkg::TEST_SETTINGS_A_ADDR) begin
            read_word = st_r.test_settings_a;
        end else if (map_addr == rts_pkg::PART_NUMBER_ID_ADDR) begin
            read_word = PART_ID;
        end else if (map_addr == rts_pkg::CHIP_REVISION_ID_ADDR) begin
            read_word = REVISION_ID;
        end else if (map_addr == rts_pkg::FREQ_OFFSET_ESTIMATE_ADDR) begin
            // Estimate is meaningless without frequency shift, so it reads flat zero
            read_word = fsk_modulation ? st_r.carrier_offset_value : rts_pkg::READ_ZERO;
        end else if (map_addr == rts_pkg::LINK_QUALITY_STATUS_ADDR) begin
            read_word = {st_r.crc_match, st_r.link_quality_value};
        end else if (map_addr == rts_pkg::SIGNAL_STRENGTH_ADDR) begin
            read_word = st_r.signal_strength;
        end else if (map_addr == rts_pkg::RADIO_FSM_STATE_ADDR) begin
            read_word = {rts_pkg::FSM_RESERVED_ZERO, radio_fsm_code};
        end else begin
            read_word = rts_pkg::READ_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state of the whole bank
    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_rd;
        if (reg_rd) begin
            st_nxt.rdata = read_word;
        end
        // Host writes reach only the test registers; status addresses fall through
        if (reg_wr) begin
            if (map_addr == rts_pkg::SYNTH_TEST_CONTROL_ADDR) begin
                st_nxt.synth_test_control = reg_wdata;
            end else if (map_addr == rts_pkg::PRODUCTION_TEST_ADDR) begin
                st_nxt.production_test = reg_wdata;
            end else if (map_addr == rts_pkg::GAIN_CONTROL_TEST_ADDR) begin
                st_nxt.gain_control_test = reg_wdata;
            end else if (map_addr == rts_pkg::TEST_SETTINGS_C_ADDR) begin
                st_nxt.test_settings_c = reg_wdata;
            end else if (map_addr == rts_pkg::TEST_SETTINGS_B_ADDR) begin
                st_nxt.test_settings_b = reg_wdata;
            end else if (map_addr == rts_pkg::TEST_SETTINGS_A_ADDR) begin
                st_nxt.test_settings_a = reg_wdata;
            end
        end
        // Retention is lost in sleep; this wins over a host write in the same cycle
        if (asleep) begin
            st_nxt.synth_test_control = rts_pkg::SYNTH_TEST_CONTROL_RESET;
            st_nxt.production_test = rts_pkg::PRODUCTION_TEST_RESET;
            st_nxt.gain_control_test = rts_pkg::GAIN_CONTROL_TEST_RESET;
            st_nxt.test_settings_c = rts_pkg::TEST_SETTINGS_C_RESET;
            st_nxt.test_settings_b = rts_pkg::TEST_SETTINGS_B_RESET;
            st_nxt.test_settings_a = rts_pkg::TEST_SETTINGS_A_RESET;
        end
        // Raw two's complement from the demodulator, no rescaling
        if (offset_update) begin
            st_nxt.carrier_offset_value = demod_offset;
        end
        // A comparison in the same cycle as a receive restart wins over the clear
        if (crc_check_done) begin
            st_nxt.crc_match = crc_match;
        end else if (rx_start) begin
            st_nxt.crc_match = 1'b0;
        end
        if (lq.lqi_done) begin
            st_nxt.link_quality_value = lq.lqi_value;
        end
        if (signal_strength_update) begin
            st_nxt.signal_strength = signal_strength_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Single state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r.synth_test_control <= rts_pkg::SYNTH_TEST_CONTROL_RESET;
            st_r.production_test <= rts_pkg::PRODUCTION_TEST_RESET;
            st_r.gain_control_test <= rts_pkg::GAIN_CONTROL_TEST_RESET;
            st_r.test_settings_c <= rts_pkg::TEST_SETTINGS_C_RESET;
            st_r.test_settings_b <= rts_pkg::TEST_SETTINGS_B_RESET;
            st_r.test_settings_a <= rts_pkg::TEST_SETTINGS_A_RESET;
            st_r.carrier_offset_value <= rts_pkg::READ_ZERO;
            st_r.crc_match <= 1'b0;
            st_r.link_quality_value <= '0;
            st_r.signal_strength <= rts_pkg::READ_ZERO;
            st_r.rdata <= rts_pkg::READ_ZERO;
            st_r.rvalid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs toward the host and the analog test hooks
    assign reg_rdata = st_r.rdata;
    assign reg_rdata_valid = st_r.rvalid;
    assign synth_test_value = st_r.synth_test_control;
    assign production_test_value = st_r.production_test;
    assign gain_test_value = st_r.gain_control_test;
    assign test_c_value = st_r.test_settings_c;
    assign test_b_value = st_r.test_settings_b;
    assign test_a_value = st_r.test_settings_a;
    // Sensor only offered in idle; host must put the default back before leaving
    assign temp_sensor_enable = st_r.production_test == rts_pkg::TEMP_SENSOR_ENABLE_VALUE
        && radio_fsm_code == rts_pkg::FSM_IDLE;
    assign osc_cal_stage_run = osc_cal_stage_request
        && st_r.test_settings_a[rts_pkg::OSC_SELECT_CAL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_production_test_sensor_write;
        reg_wr && map_addr == rts_pkg::PRODUCTION_TEST_ADDR
            && reg_wdata == rts_pkg::TEMP_SENSOR_ENABLE_VALUE && !asleep;
    endsequence

    sequence s_crc_matched;
        crc_check_done && crc_match;
    endsequence

    sequence s_read_quality;
        reg_rd && map_addr == rts_pkg::LINK_QUALITY_STATUS_ADDR && !crc_check_done && !rx_start;
    endsequence

    AST_SLEEP_RELOAD: assert property (@(posedge clock) disable iff (!rst_n)
        asleep |=> st_r.test_settings_a == rts_pkg::TEST_SETTINGS_A_RESET
            && st_r.production_test == rts_pkg::PRODUCTION_TEST_RESET
            && st_r.synth_test_control == rts_pkg::SYNTH_TEST_CONTROL_RESET)
        else $error("test registers kept their contents through sleep");

    AST_TEMP_SENSOR: assert property (@(posedge clock) disable iff (!rst_n)
        s_production_test_sensor_write ##1 (radio_fsm_code == rts_pkg::FSM_IDLE) |-> temp_sensor_enable)
        else $error("temperature sensor not offered after enabling write in idle");

    AST_OSC_CAL_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr && map_addr == rts_pkg::TEST_SETTINGS_A_ADDR && !reg_wdata[rts_pkg::OSC_SELECT_CAL_ENABLE_BIT]
            && !asleep ##1 !(reg_wr && map_addr == rts_pkg::TEST_SETTINGS_A_ADDR) && !asleep
        |-> !osc_cal_stage_run)
        else $error("oscillator calibration ran while disabled");

    AST_MIRROR_STATE: assert property (@(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == rts_pkg::ALT_STATUS_LAST
        |=> reg_rdata_valid && reg_rdata == {rts_pkg::FSM_RESERVED_ZERO, $past(radio_fsm_code)})
        else $error("mirrored state read returned wrong value");

    // Any write into the status window leaves every captured status value alone
    AST_RO_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr && map_addr >= rts_pkg::STATUS_BASE && !offset_update && !crc_check_done && !rx_start
            && !lq.lqi_done && !signal_strength_update
        |=> $stable(st_r.carrier_offset_value) && $stable(st_r.crc_match)
            && $stable(st_r.link_quality_value) && $stable(st_r.signal_strength))
        else $error("write to read-only status register changed it");

    AST_OFFSET_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        reg_rd && map_addr == rts_pkg::FREQ_OFFSET_ESTIMATE_ADDR && !fsk_modulation
        |=> reg_rdata == rts_pkg::READ_ZERO)
        else $error("offset estimate nonzero under amplitude keying");

    AST_CRC_SET: assert property (@(posedge clock) disable iff (!rst_n)
        s_crc_matched ##1 !rx_start && !crc_check_done ##1 s_read_quality |=> reg_rdata[rts_pkg::CRC_MATCH_BIT])
        else $error("CRC match flag missing after matched comparison");

    AST_CRC_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        rx_start && !crc_check_done ##1 !crc_check_done ##1 s_read_quality |=> !reg_rdata[rts_pkg::CRC_MATCH_BIT])
        else $error("CRC match flag survived receive restart");

    AST_SIGNAL_STRENGTH_READ: assert property (@(posedge clock) disable iff (!rst_n)
        signal_strength_update ##1 !signal_strength_update ##1 (reg_rd && map_addr == rts_pkg::SIGNAL_STRENGTH_ADDR && !signal_strength_update)
        |=> reg_rdata == $past(signal_strength_value, 3))
        else $error("signal strength read did not return captured value");
endmodule

// file: bench/rts_host.sv
// Host model for the register bank: one register access at a time.
// Assumes the bank takes requests on rising edges; this side moves on falling ones.
module rts_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One access, writes to 0x29 and 0x2B dropped; released lines show the inverse so a stale value never passes
    task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
        if (wr && (addr == 8'h29 || addr == 8'h2B)) begin
            return;
        end
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~addr;
        reg_wdata = ~data;
    endtask
endmodule

// file: bench/radio_test_and_status_registers_test.sv
// Self-checking bench for the radio test and status register bank.
// Assumes rts_host drives the register port; radio-side events come from here.
module radio_test_and_status_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PART = 8'h6C; // Arbitrary value
    localparam logic [7:0] REV = 8'h2E; // Arbitrary value
    logic clock = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, reg_rdata_valid, osc_cal_stage_run, temp_sensor_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, demod_offset = 8'h00, signal_strength_value = 8'h00;
    logic fsk_modulation = 1'b1, offset_update = 1'b0, crc_check_done = 1'b0, crc_match = 1'b0, rx_start = 1'b0;
    logic sync_found = 1'b0, symbol_strobe = 1'b0, signal_strength_update = 1'b0, osc_cal_stage_request = 1'b0;
    logic [4:0] radio_fsm_code = 5'h01;
    logic [6:0] symbol_quality = 7'h00;
    logic [7:0] exp_q[$];
    logic [7:0] resets [6] = '{8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B};
    logic [7:0] tv [6];
    int n_fail = 0, checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Design, host and clock; short quality window keeps the run brief
    rts_bank #(.PART_ID(PART), .REVISION_ID(REV), .LQI_SYMBOLS(4)) i_rts_bank (.clock, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rdata_valid, .radio_fsm_code, .fsk_modulation,
        .offset_update, .demod_offset, .crc_check_done, .crc_match, .rx_start, .sync_found, .symbol_strobe,
        .symbol_quality, .signal_strength_update, .signal_strength_value, .osc_cal_stage_request, .osc_cal_stage_run,
        .temp_sensor_enable, .synth_test_value(tv[0]), .production_test_value(tv[1]), .gain_test_value(tv[2]),
        .test_c_value(tv[3]), .test_b_value(tv[4]), .test_a_value(tv[5]));
    rts_host i_rts_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    // Checking and reporting
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Read with its expected value noted before the request goes out
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        i_rts_host.access(addr, 8'h00, 1'b0);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask

    // Read data matched to the oldest note; an unexpected answer never matches
    always @(negedge clock) begin
        if (reg_rdata_valid === 1'b1) begin
            check("reg_rdata", reg_rdata, (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx);
        end
    end

    // Hang guard
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int sum;
        logic [7:0] v;
        void'($urandom(32'hff83));
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        foreach (resets[i]) rd(8'h29 + 8'(i), resets[i]);
        foreach (resets[i]) check("test_value", tv[i], resets[i]);
        i_rts_host.access(8'h30, 8'h00, 1'b1);
        rd(8'h30, PART);
        rd(8'hF1, REV);
        rd(8'h36, 8'h00);
        for (int c = 0; c < 23; c++) begin
            radio_fsm_code = 5'(c);
            rd(8'hF5, 8'(c));
        end
        radio_fsm_code = 5'h01;
        // Temperature sensor only while the magic value sits in production test
        i_rts_host.access(8'h2A, 8'hBF, 1'b1);
        @(negedge clock);
        check("temp_sensor_enable", {7'h00, temp_sensor_enable}, 8'h01);
        i_rts_host.access(8'h2A, 8'h7F, 1'b1);
        @(negedge clock);
        check("temp_sensor_enable", {7'h00, temp_sensor_enable}, 8'h00);
        // Calibration stage gate, then sleep restores the enable bit
        osc_cal_stage_request = 1'b1;
        #1;
        check("osc_cal_stage_run", {7'h00, osc_cal_stage_run}, 8'h01);
        i_rts_host.access(8'h2E, 8'h09, 1'b1);
        @(negedge clock);
        check("osc_cal_stage_run", {7'h00, osc_cal_stage_run}, 8'h00);
        rd(8'h2E, 8'h09);
        radio_fsm_code = 5'h00;
        repeat (2) @(negedge clock);
        radio_fsm_code = 5'h01;
        rd(8'h2E, 8'h0B);
        check("osc_cal_stage_run", {7'h00, osc_cal_stage_run}, 8'h01);
        // Offset estimate, forced to zero without frequency-shift keying
        v = 8'($urandom);
        demod_offset = v;
        pulse(offset_update);
        rd(8'hF2, v);
        fsk_modulation = 1'b0;
        rd(8'h32, 8'h00);
        fsk_modulation = 1'b1;
        // CRC flag set by a match, cleared by receive restart
        crc_match = 1'b1;
        pulse(crc_check_done);
        rd(8'h33, 8'h80);
        pulse(rx_start);
        rd(8'h33, 8'h00);
        // Quality averaged over the window after sync
        sum = 0;
        pulse(sync_found);
        repeat (4) begin
            symbol_quality = 7'($urandom);
            sum += symbol_quality;
            pulse(symbol_strobe);
        end
        repeat (3) @(negedge clock);
        rd(8'hF3, 8'(sum / 4));
        v = 8'($urandom);
        signal_strength_value = v;
        pulse(signal_strength_update);
        rd(8'hF4, v);
        i_rts_host.access(8'h34, ~v, 1'b1);
        rd(8'hF4, v);
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clock);
        if (exp_q.size() != 0) begin
            n_fail++;
        end
        end_of_test();
    end
endmodule
